// ===== bench/test_usb_full_speed_device_port.sv
`timescale 1ns/10ps
module test_usb_full_speed_device_port;
  import ufp_pkg::*;
  // ------------------------------------------------
  // signals, design and host
  // ------------------------------------------------
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic dp_in, dm_in, dp_out, dm_out, dp_oe_n, host_presence_input;
  logic external_resume, dp_pullup_control, host_present, ep_dir_in;
  logic ping_pong_en, iso_mode, dev_ready, self_powered, tok_valid;
  logic rx_valid, rx_end, hs_valid, tx_valid, tx_last, tx_zero, tx_ready;
  logic hs_out_valid, cpu_wr_valid, cpu_wr_ready, cpu_commit, cpu_rd_req;
  logic cpu_rd_valid, cpu_release, bank_ready, cpu_clr_setup;
  logic cpu_clr_transmit_complete_flag, cpu_clr_susp, cpu_clr_resume, setup_received_flag;
  logic transmit_complete_flag, suspend_flag, resume_flag, suspended, irq;
  logic [3:0] tok_pid, hs_pid, hs_out_pid;
  logic [7:0] rx_byte, tx_byte, cpu_wr_data, cpu_rd_data;
  logic [7:0] d [16];
  int n_fail, num_checks, cyc, n;
  ufp_device_port #(.SUSP_CYCLES_P(20), .RESUME_CYCLES_P(8)) DUT (.*);
  ufp_host_model host (.*);
  always #50 core_clk = ~core_clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic reset_dut;
    sys_rst = 1'b1;
    tick(4);
    sys_rst = 1'b0;
    tick(2);
  endtask
  // token, k random data bytes, end; waits for the handshake
  task automatic rx_pkt(input logic [3:0] pid, input int k);
    tok_pid = pid;
    pulse(tok_valid);
    for (int i = 0; i < k; i++) begin
      d[i] = 8'($urandom);
      rx_valid = 1'b1;
      rx_byte = d[i];
      tick(1);
    end
    rx_valid = 1'b0;
    pulse(rx_end);
    while (hs_out_valid !== 1'b1) tick(1);
  endtask
  // k bytes through the buffer into the cpu bank, then hand it over
  task automatic fill(input int k, input int o);
    cpu_wr_valid = 1'b1;
    for (int i = 0; i < k; i++) begin
      d[o+i] = 8'($urandom);
      cpu_wr_data = d[o+i];
      chk(cpu_wr_ready, 1'b1);
      tick(1);
    end
    cpu_wr_valid = 1'b0;
    tick(2);
    pulse(cpu_commit);
    tick(3);
  endtask
  // IN token, check each byte as the host takes it, then the flag
  task automatic send(input int k, input int o);
    tok_pid = PID_IN;
    pulse(tok_valid);
    for (int i = 0; i < k;) begin
      @(posedge core_clk);
      if (tx_valid && tx_ready) begin
        chk(tx_byte, d[o+i]);
        chk(tx_last, i == k - 1);
        chk(tx_zero, 1'b0);
        i++;
      end
    end
    while (transmit_complete_flag !== 1'b1) tick(1);
    tick(1);
    chk(irq, 1'b1);
    pulse(cpu_clr_transmit_complete_flag);
    chk(transmit_complete_flag, 1'b0);
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // a hang ends the run as a failure
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_fail++;
      print_verdict;
    end
  end
  initial begin
    {dp_in, dm_in, host_presence_input, external_resume, ep_dir_in} = '0;
    {ping_pong_en, iso_mode, dev_ready, self_powered, tok_valid} = '0;
    {rx_valid, rx_end, cpu_wr_valid, cpu_commit, cpu_rd_req} = '0;
    {cpu_release, cpu_clr_setup, cpu_clr_transmit_complete_flag, cpu_clr_susp} = '0;
    {cpu_clr_resume, tok_pid, rx_byte, cpu_wr_data} = '0;
    n = $urandom(32'hD63A);
    reset_dut;
    chk(irq, 1'b0);
    chk(dp_oe_n, 1'b1);
    chk(dp_pullup_control, 1'b0);
    dev_ready = 1'b1;
    self_powered = 1'b1;
    tick(4);
    chk(dp_pullup_control, 1'b0);
    chk(host_present, 1'b0);
    host_presence_input = 1'b1;
    tick(4);
    chk(dp_pullup_control, 1'b1);
    chk(host_present, 1'b1);
    rx_pkt(PID_SETUP, 8);
    chk(hs_out_pid, PID_ACK);
    tick(1);
    chk(setup_received_flag, 1'b1);
    chk(irq, 1'b1);
    cpu_rd_req = 1'b1;
    for (int i = 0; i < 8; i++) begin
      tick(1);
      chk(cpu_rd_valid, 1'b1);
      chk(cpu_rd_data, d[i]);
    end
    tick(1);
    chk(cpu_rd_valid, 1'b0);
    cpu_rd_req = 1'b0;
    // free the bank so only the pending setup can refuse the OUT
    pulse(cpu_release);
    rx_pkt(PID_OUT, 1);
    chk(hs_out_pid, PID_NAK);
    pulse(cpu_clr_setup);
    tick(1);
    chk(irq, 1'b0);
    ep_dir_in = 1'b1;
    reset_dut;
    chk(bank_ready, 1'b1);
    n = $urandom_range(8, 1);
    fill(n, 0);
    chk(bank_ready, 1'b0);
    send(n, 0);
    chk(bank_ready, 1'b1);
    ping_pong_en = 1'b1;
    fill(n, 0);
    chk(bank_ready, 1'b1);
    fill(8, 8);
    chk(bank_ready, 1'b0);
    send(n, 0);
    chk(bank_ready, 1'b1);
    send(8, 8);
    ping_pong_en = 1'b0;
    iso_mode = 1'b1;
    fill(n, 0);
    chk(bank_ready, 1'b1);
    send(n, 0);
    dp_in = 1'b1;
    tick(30);
    chk(suspended, 1'b1);
    chk(suspend_flag, 1'b1);
    external_resume = 1'b1;
    tick(4);
    chk(dp_oe_n, 1'b0);
    chk(dp_out, 1'b0);
    chk(dm_out, 1'b1);
    external_resume = 1'b0;
    tick(8);
    chk(dp_oe_n, 1'b1);
    dp_in = 1'b0;
    tick(4);
    chk(resume_flag, 1'b1);
    chk(suspended, 1'b0);
    pulse(cpu_clr_susp);
    chk(suspend_flag, 1'b0);
    pulse(cpu_clr_resume);
    chk(irq, 1'b0);
    print_verdict;
  end
endmodule

// ===== bench/ufp_host_model.sv
`timescale 1ns/10ps
module ufp_host_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // device transmit stream
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready = 1'b0,
  output logic hs_valid = 1'b0,
  output logic [3:0] hs_pid
);
  import ufp_pkg::*;
  logic ack_due = 1'b0;
  // random stalls force the port to hold each byte until it is taken
  always @(negedge core_clk) begin
    tx_ready <= !sys_rst && ($urandom_range(3) != 0);
    hs_valid <= ack_due;
  end
  always @(posedge core_clk) begin
    ack_due <= tx_valid && tx_ready && tx_last;
  end
  assign hs_pid = PID_ACK;
endmodule

// ===== rtl/ufp_device_port.sv
`timescale 1ns/10ps
module ufp_device_port #(
  parameter int SUSP_CYCLES_P = ufp_pkg::SUSP_CYCLES,
  parameter int RESUME_CYCLES_P = ufp_pkg::RESUME_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // transceiver pad
  input wire logic dp_in,
  input wire logic dm_in,
  output logic dp_out,
  output logic dm_out,
  output logic dp_oe_n,
  // board lines
  input wire logic host_presence_input,
  input wire logic external_resume,
  output logic dp_pullup_control,
  output logic host_present,
  // endpoint configuration
  input wire logic ep_dir_in,
  input wire logic ping_pong_en,
  input wire logic iso_mode,
  input wire logic dev_ready,
  input wire logic self_powered,
  // packet engine
  input wire logic tok_valid,
  input wire logic [3:0] tok_pid,
  input wire logic rx_valid,
  input wire logic [ufp_pkg::DATA_W-1:0] rx_byte,
  input wire logic rx_end,
  input wire logic hs_valid,
  input wire logic [3:0] hs_pid,
  output logic tx_valid,
  output logic [ufp_pkg::DATA_W-1:0] tx_byte,
  output logic tx_last,
  output logic tx_zero,
  input wire logic tx_ready,
  output logic hs_out_valid,
  output logic [3:0] hs_out_pid,
  // processor side
  input wire logic cpu_wr_valid,
  input wire logic [ufp_pkg::DATA_W-1:0] cpu_wr_data,
  output logic cpu_wr_ready,
  input wire logic cpu_commit,
  input wire logic cpu_rd_req,
  output logic cpu_rd_valid,
  output logic [ufp_pkg::DATA_W-1:0] cpu_rd_data,
  input wire logic cpu_release,
  output logic bank_ready,
  input wire logic cpu_clr_setup,
  input wire logic cpu_clr_transmit_complete_flag,
  input wire logic cpu_clr_susp,
  input wire logic cpu_clr_resume,
  // status
  output logic setup_received_flag,
  output logic transmit_complete_flag,
  output logic suspend_flag,
  output logic resume_flag,
  output logic suspended,
  output logic irq
);
  import ufp_pkg::*;
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [PINS-1:0] pin_s1, pin_s2, next_pin_s1, next_pin_s2;
  logic [1:0] line;
  ufp_bus_state_t state, next_state;
  logic [BANKS-1:0] full, next_full;
  logic [CNT_W-1:0] cnt [BANKS];
  logic [CNT_W-1:0] next_cnt [BANKS];
  logic [CNT_W-1:0] cpu_ptr, next_cpu_ptr, bus_ptr, next_bus_ptr;
  logic cpu_bank, next_cpu_bank, bus_bank, next_bus_bank;
  logic commit_pend, next_commit_pend, setup_cur, next_setup_cur;
  logic two_bank, next_tx_valid, next_tx_last, next_tx_zero;
  logic next_hs_valid, next_rd_valid, next_bank_ready;
  logic [3:0] next_hs_pid;
  logic next_setup_flag, next_transmit_complete_flag;
  logic fifo_out_valid, fifo_out_ready;
  logic [DATA_W-1:0] fifo_out_data;
  logic a_we, a_re, b_we, b_re;
  logic [CNT_W-1:0] a_addr, b_addr;
  logic [TMR_W-1:0] idle_cnt, next_idle_cnt, drive_cnt, next_drive_cnt;
  logic driving, next_driving, next_suspended, active;
  logic next_susp_flag, next_resume_flag;
  logic next_pullup, next_irq;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // pads and board lines are asynchronous to core_clk
  always_comb begin
    next_pin_s1 = {external_resume, host_presence_input, dm_in, dp_in};
    next_pin_s2 = pin_s1;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
    end else begin
      pin_s1 <= next_pin_s1;
      pin_s2 <= next_pin_s2;
    end
  end

  assign line = {pin_s2[PIN_DP], pin_s2[PIN_DM]};

  // ----------------------------------------------------------------
  // byte buffer and payload banks
  // ----------------------------------------------------------------
  ufp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(cpu_wr_valid),
    .in_ready(cpu_wr_ready),
    .in_data(cpu_wr_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  ufp_payload_ram #(.WIDTH(DATA_W), .DEPTH(RAM_DEPTH)) u_ram (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .a_we(a_we),
    .a_re(a_re),
    .a_addr(a_addr),
    .a_wdata(fifo_out_data),
    .a_rdata(cpu_rd_data),
    .b_we(b_we),
    .b_re(b_re),
    .b_addr(b_addr),
    .b_wdata(rx_byte),
    .b_rdata(tx_byte)
  );

  // ----------------------------------------------------------------
  // bank ownership, processor port and bus sequencer
  // ----------------------------------------------------------------
  // bus side shares core_clk with the processor side, no crossing
  assign two_bank = ping_pong_en | iso_mode;

  always_comb begin
    next_full = full;
    next_cnt = cnt;
    next_cpu_ptr = cpu_ptr;
    next_bus_ptr = bus_ptr;
    next_cpu_bank = cpu_bank;
    next_bus_bank = bus_bank;
    next_commit_pend = commit_pend | cpu_commit;
    next_state = state;
    next_setup_cur = setup_cur;
    next_tx_valid = tx_valid;
    next_tx_last = tx_last;
    next_tx_zero = tx_zero;
    next_hs_valid = 1'b0;
    next_hs_pid = hs_out_pid;
    next_rd_valid = 1'b0;
    next_setup_flag = setup_received_flag & ~cpu_clr_setup;
    next_transmit_complete_flag = transmit_complete_flag & ~cpu_clr_transmit_complete_flag;
    fifo_out_ready = 1'b0;
    a_we = 1'b0;
    a_re = 1'b0;
    b_we = 1'b0;
    b_re = 1'b0;
    a_addr = {cpu_bank, cpu_ptr[PTR_W-1:0]};
    b_addr = {bus_bank, bus_ptr[PTR_W-1:0]};
    if (ep_dir_in) begin
      // a commit waits for the buffer to drain into the bank
      if (fifo_out_valid && !full[cpu_bank] && cpu_ptr != BANK_LIMIT) begin
        fifo_out_ready = 1'b1;
        a_we = 1'b1;
        next_cpu_ptr = cpu_ptr + CNT_ONE;
      end else if (commit_pend && !fifo_out_valid && !full[cpu_bank]) begin
        next_full[cpu_bank] = 1'b1;
        next_cnt[cpu_bank] = cpu_ptr;
        next_cpu_ptr = CNT_ZERO;
        next_cpu_bank = next_bank(cpu_bank, two_bank);
        next_commit_pend = 1'b0;
      end
    end else begin
      next_commit_pend = 1'b0;
      if (cpu_rd_req && full[cpu_bank] && cpu_ptr != cnt[cpu_bank]) begin
        a_re = 1'b1;
        next_rd_valid = 1'b1;
        next_cpu_ptr = cpu_ptr + CNT_ONE;
      end else if (cpu_release && full[cpu_bank]) begin
        next_full[cpu_bank] = 1'b0;
        next_cpu_ptr = CNT_ZERO;
        next_cpu_bank = next_bank(cpu_bank, two_bank);
      end
    end
    case (state)
      B_IDLE: begin
        if (tok_valid && tok_pid == PID_IN && ep_dir_in) begin
          if (full[bus_bank]) begin
            next_bus_ptr = CNT_ZERO;
            if (cnt[bus_bank] == CNT_ZERO) begin
              next_tx_valid = 1'b1;
              next_tx_last = 1'b1;
              next_tx_zero = 1'b1;
              next_state = B_TX;
            end else begin
              next_state = B_FETCH;
            end
          end else begin
            next_hs_valid = 1'b1;
            next_hs_pid = PID_NAK;
          end
        end else if (tok_valid && tok_pid == PID_SETUP) begin
          next_setup_cur = 1'b1;
          next_bus_ptr = CNT_ZERO;
          next_state = B_RX;
        end else if (tok_valid && tok_pid == PID_OUT) begin
          // a pending setup blocks OUT data so it cannot be overwritten
          if (!ep_dir_in && !full[bus_bank] && !setup_received_flag) begin
            next_bus_ptr = CNT_ZERO;
            next_state = B_RX;
          end else begin
            next_state = B_DROP;
          end
        end
      end
      B_FETCH: begin
        b_re = 1'b1;
        next_tx_valid = 1'b1;
        next_tx_zero = 1'b0;
        next_tx_last = (bus_ptr + CNT_ONE) == cnt[bus_bank];
        next_state = B_TX;
      end
      B_TX: begin
        if (tx_ready) begin
          next_tx_valid = 1'b0;
          if (!tx_last) begin
            next_bus_ptr = bus_ptr + CNT_ONE;
            next_state = B_FETCH;
          end else if (iso_mode) begin
            // isochronous data gets no handshake, release at once
            next_full[bus_bank] = 1'b0;
            next_transmit_complete_flag = 1'b1;
            next_bus_bank = next_bank(bus_bank, two_bank);
            next_state = B_IDLE;
          end else begin
            next_state = B_WAIT_ACK;
          end
        end
      end
      B_WAIT_ACK: begin
        if (hs_valid && hs_pid == PID_ACK) begin
          next_full[bus_bank] = 1'b0;
          next_transmit_complete_flag = 1'b1;
          next_bus_bank = next_bank(bus_bank, two_bank);
          next_state = B_IDLE;
        end else if (hs_valid || tok_valid) begin
          // no ACK: the bank stays loaded for the host's retry
          next_state = B_IDLE;
        end
      end
      B_RX: begin
        // bytes past the bank size are dropped, the count saturates
        if (rx_valid && bus_ptr != BANK_LIMIT) begin
          b_we = 1'b1;
          next_bus_ptr = bus_ptr + CNT_ONE;
        end
        if (rx_end) begin
          next_full[bus_bank] = 1'b1;
          next_cnt[bus_bank] = bus_ptr;
          next_hs_valid = 1'b1;
          next_hs_pid = PID_ACK;
          next_setup_cur = 1'b0;
          if (setup_cur) begin
            next_setup_flag = 1'b1;
          end else begin
            next_bus_bank = next_bank(bus_bank, two_bank);
          end
          next_state = B_IDLE;
        end
      end
      B_DROP: begin
        if (rx_end) begin
          next_hs_valid = 1'b1;
          next_hs_pid = PID_NAK;
          next_state = B_IDLE;
        end
      end
      default: begin
        next_state = B_IDLE;
      end
    endcase
    next_bank_ready = ep_dir_in ? ~next_full[next_cpu_bank]
                                : next_full[next_cpu_bank];
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= B_IDLE;
      full <= 2'h0;
      cnt <= '{default: 7'h00};
      cpu_ptr <= 7'h00;
      bus_ptr <= 7'h00;
      cpu_bank <= 1'b0;
      bus_bank <= 1'b0;
      commit_pend <= 1'b0;
      setup_cur <= 1'b0;
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
      tx_zero <= 1'b0;
      hs_out_valid <= 1'b0;
      hs_out_pid <= 4'h0;
      cpu_rd_valid <= 1'b0;
      bank_ready <= 1'b0;
      setup_received_flag <= 1'b0;
      transmit_complete_flag <= 1'b0;
    end else begin
      state <= next_state;
      full <= next_full;
      cnt <= next_cnt;
      cpu_ptr <= next_cpu_ptr;
      bus_ptr <= next_bus_ptr;
      cpu_bank <= next_cpu_bank;
      bus_bank <= next_bus_bank;
      commit_pend <= next_commit_pend;
      setup_cur <= next_setup_cur;
      tx_valid <= next_tx_valid;
      tx_last <= next_tx_last;
      tx_zero <= next_tx_zero;
      hs_out_valid <= next_hs_valid;
      hs_out_pid <= next_hs_pid;
      cpu_rd_valid <= next_rd_valid;
      bank_ready <= next_bank_ready;
      setup_received_flag <= next_setup_flag;
      transmit_complete_flag <= next_transmit_complete_flag;
    end
  end

  // ----------------------------------------------------------------
  // suspend, resume and remote wake-up
  // ----------------------------------------------------------------
  assign active = (line != LINE_J) || tok_valid || rx_valid;

  always_comb begin
    next_idle_cnt = idle_cnt;
    next_drive_cnt = drive_cnt;
    next_driving = driving;
    next_suspended = suspended;
    next_susp_flag = suspend_flag & ~cpu_clr_susp;
    next_resume_flag = resume_flag & ~cpu_clr_resume;
    if (driving) begin
      // our own K on the line must not look like a host resume
      next_idle_cnt = TMR_ZERO;
      next_drive_cnt = drive_cnt - TMR_ONE;
      if (drive_cnt == TMR_ONE) begin
        next_driving = 1'b0;
      end
    end else if (active) begin
      next_idle_cnt = TMR_ZERO;
      if (suspended) begin
        next_suspended = 1'b0;
        next_resume_flag = 1'b1;
      end
    end else if (suspended && pin_s2[PIN_WAKE]) begin
      next_driving = 1'b1;
      next_drive_cnt = TMR_W'(RESUME_CYCLES_P);
    end else if (!suspended) begin
      if (idle_cnt == TMR_W'(SUSP_CYCLES_P - 1)) begin
        next_suspended = 1'b1;
        next_susp_flag = 1'b1;
      end else begin
        next_idle_cnt = idle_cnt + TMR_ONE;
      end
    end
    next_pullup = dev_ready & (~self_powered | pin_s2[PIN_VBUS]);
    next_irq = next_setup_flag | next_transmit_complete_flag | next_susp_flag
             | next_resume_flag;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idle_cnt <= 17'h00000;
      drive_cnt <= 17'h00000;
      driving <= 1'b0;
      suspended <= 1'b0;
      suspend_flag <= 1'b0;
      resume_flag <= 1'b0;
      dp_out <= 1'b1;
      dm_out <= 1'b0;
      dp_oe_n <= 1'b1;
      dp_pullup_control <= 1'b0;
      host_present <= 1'b0;
      irq <= 1'b0;
    end else begin
      idle_cnt <= next_idle_cnt;
      drive_cnt <= next_drive_cnt;
      driving <= next_driving;
      suspended <= next_suspended;
      suspend_flag <= next_susp_flag;
      resume_flag <= next_resume_flag;
      dp_out <= ~next_driving;
      dm_out <= next_driving;
      dp_oe_n <= ~next_driving;
      dp_pullup_control <= next_pullup;
      host_present <= pin_s2[PIN_VBUS];
      irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_in_sent;
    state == B_TX && tx_ready && tx_last && !iso_mode;
  endsequence
  sequence s_host_ack;
    state == B_WAIT_ACK && hs_valid && hs_pid == PID_ACK;
  endsequence

  a_bank_split: assert property (a_we && b_we |->
    a_addr[PTR_W] != b_addr[PTR_W]) else $error("both ports on one bank");
  a_pingpong_swap: assert property (s_in_sent ##1 s_host_ack
    |=> bus_bank == (two_bank ? ~$past(bus_bank, 2) : 1'b0))
    else $error("bus bank did not swap after ack");
  a_transmit_complete_flag_ack: assert property (s_host_ack |=>
    transmit_complete_flag && irq) else $error("ack did not set complete");
  a_setup_ack: assert property (state == B_RX && setup_cur && rx_end
    |=> setup_received_flag && hs_out_valid && hs_out_pid == PID_ACK)
    else $error("setup not acknowledged");
  a_setup_hold: assert property (setup_received_flag && !cpu_clr_setup
    |=> setup_received_flag) else $error("setup flag dropped");
  a_irq_line: assert property ((setup_received_flag || suspend_flag)
    |-> irq) else $error("pending event without interrupt");
  a_suspend_det: assert property ($rose(suspended) |->
    $past(idle_cnt) == TMR_W'(SUSP_CYCLES_P - 1) && suspend_flag)
    else $error("suspend without full idle time");
  a_wake_drive: assert property (suspended && !driving && !active
    && pin_s2[PIN_WAKE] |=> (!dp_oe_n && !dp_out && dm_out) [*2])
    else $error("wake did not drive resume");
  a_pullup_loss: assert property (self_powered && !pin_s2[PIN_VBUS]
    |=> !dp_pullup_control) else $error("pull-up kept without bus power");
  a_pullup_ready: assert property (!dev_ready |=>
    !dp_pullup_control) else $error("pull-up before device ready");
endmodule

// ===== rtl/ufp_fifo.sv
`timescale 1ns/10ps
module ufp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic next_in_ready, push, pop;

  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr = wr_ptr + AW'(1);
    end
    if (pop) begin
      next_rd_ptr = rd_ptr + AW'(1);
    end
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    // ready is registered so the source never sees a combinational path
    next_in_ready = (next_count != FULL_CNT);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready <= next_in_ready;
    end
  end

  always_ff @(posedge core_clk) begin
    mem <= next_mem;
  end
endmodule

// ===== rtl/ufp_payload_ram.sv
`timescale 1ns/10ps
module ufp_payload_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // processor port
  input wire logic a_we,
  input wire logic a_re,
  input wire logic [$clog2(DEPTH)-1:0] a_addr,
  input wire logic [WIDTH-1:0] a_wdata,
  output logic [WIDTH-1:0] a_rdata,
  // bus port
  input wire logic b_we,
  input wire logic b_re,
  input wire logic [$clog2(DEPTH)-1:0] b_addr,
  input wire logic [WIDTH-1:0] b_wdata,
  output logic [WIDTH-1:0] b_rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [WIDTH-1:0] next_a_rdata, next_b_rdata;

  // the top does not keep the two ports on different banks; a SETUP to an IN endpoint can make both write at once
  always_comb begin
    next_mem = mem;
    next_a_rdata = a_re ? mem[a_addr] : a_rdata;
    next_b_rdata = b_re ? mem[b_addr] : b_rdata;
    if (a_we) begin
      next_mem[a_addr] = a_wdata;
    end
    if (b_we) begin
      next_mem[b_addr] = b_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      a_rdata <= 8'h00;
      b_rdata <= 8'h00;
    end else begin
      a_rdata <= next_a_rdata;
      b_rdata <= next_b_rdata;
    end
  end

  always_ff @(posedge core_clk) begin
    mem <= next_mem;
  end
endmodule

// ===== rtl/ufp_pkg.sv
package ufp_pkg;
  // ----------------------------------------------------------------
  // clocking and rates
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int CLK_PERIOD_NS = 100;
  localparam int BUS_RATE_MBPS = 12;
  localparam int SUSP_TIME_US = 3000;
  localparam int SUSP_CYCLES = SUSP_TIME_US * CLK_MHZ;
  localparam int RESUME_TIME_US = 10000;
  localparam int RESUME_CYCLES = RESUME_TIME_US * CLK_MHZ;
  localparam int TMR_W = 17;
  localparam logic [TMR_W-1:0] TMR_ONE = 17'h00001;
  localparam logic [TMR_W-1:0] TMR_ZERO = 17'h00000;
  // ----------------------------------------------------------------
  // payload storage
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int BANKS = 2;
  localparam int BANK_BYTES = 64;
  localparam int PTR_W = 6;
  localparam int CNT_W = 7;
  localparam int RAM_DEPTH = BANKS * BANK_BYTES;
  localparam int FIFO_DEPTH = 8;
  localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
  localparam logic [CNT_W-1:0] BANK_LIMIT = 7'h40;
  // ----------------------------------------------------------------
  // packet ids, line states, pin positions
  // ----------------------------------------------------------------
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_SETUP = 4'hD;
  localparam logic [3:0] PID_ACK = 4'h2;
  localparam logic [3:0] PID_NAK = 4'hA;
  localparam logic [1:0] LINE_J = 2'h2;
  localparam logic [1:0] LINE_K = 2'h1;
  localparam int PINS = 4;
  localparam int PIN_DP = 0;
  localparam int PIN_DM = 1;
  localparam int PIN_VBUS = 2;
  localparam int PIN_WAKE = 3;
  typedef enum logic [2:0] {
    B_IDLE, B_FETCH, B_TX, B_WAIT_ACK, B_RX, B_DROP
  } ufp_bus_state_t;
  // ----------------------------------------------------------------
  // bank selection
  // ----------------------------------------------------------------
  function automatic logic next_bank(input logic bank, input logic two);
    next_bank = two ? ~bank : 1'b0;
  endfunction
endpackage
